//--- hdl/timer_pkg.sv
/*
 * Shared constants and types for the auto-reload capture/compare timer:
 * register indices, register field layouts, mode codes and state records.
 * Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
 */
`default_nettype none

package timer_pkg;
	// =====================================================================
	// register indices (byte address is four times the index)
	localparam int unsigned IDX_W = 5;
	localparam logic [IDX_W-1:0] IDX_CTRL_A = 5'h00;
	localparam logic [IDX_W-1:0] IDX_VALUE_HI = 5'h01;
	localparam logic [IDX_W-1:0] IDX_RELOAD_HI = 5'h02;
	localparam logic [IDX_W-1:0] IDX_CMP_HI = 5'h03;
	localparam logic [IDX_W-1:0] IDX_CTRL_B = 5'h08;
	localparam logic [IDX_W-1:0] IDX_VALUE = 5'h09;
	localparam logic [IDX_W-1:0] IDX_RELOAD = 5'h0A;
	localparam logic [IDX_W-1:0] IDX_CMP = 5'h0B;
	localparam logic [IDX_W-1:0] IDX_CFG = 5'h10;
	localparam int unsigned ADDR_W = IDX_W + 2;

	// =====================================================================
	// widths, codes and limits
	localparam int unsigned TIMER_W = 16;
	localparam int unsigned PRESC_W = 7;
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [15:0] FULL_16 = 16'hFFFF;
	localparam logic [7:0] FULL_8 = 8'hFF;
	localparam logic [7:0] ZERO_8 = 8'h00;

	// =====================================================================
	// register layouts, reset value of each is all zero
	typedef struct packed {
		logic reserved;
		logic [2:0] prescale_select;
		logic dual_byte_mode;
		logic [1:0] edge_function_select;
		logic counter_timer_select;
	} cfg_t;

	typedef struct packed {
		logic main_irq_enable;
		logic pin_output_enable;
		logic pin_polarity;
		logic low_unit_run;
		logic main_run;
		logic capture_reload_enable;
		logic single_shot;
		logic gate_enable;
	} ctrl_a_t;

	typedef struct packed {
		logic low_irq_enable;
		logic [2:0] reserved;
		logic main_overflow_flag;
		logic low_overflow_flag;
		logic capture_compare_flag;
		logic low_compare_flag;
	} ctrl_b_t;

	typedef enum logic [1:0] {SS_IDLE, SS_WAIT, SS_CAPT, SS_CMP} ss_state_t;

	// =====================================================================
	// module state records
	typedef struct packed {
		cfg_t cfg;
		ctrl_a_t ca;
		ctrl_b_t cb;
		logic [15:0] value;
		logic [15:0] reload;
		logic [15:0] cmp;
		ss_state_t ss;
		logic pwm;
		logic pwm_start;
		logic pin_out;
		logic pin_oe;
		logic irq_main;
		logic irq_low;
		logic aw_full;
		logic aw_rdy;
		logic [IDX_W-1:0] aw_idx;
		logic w_full;
		logic w_rdy;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
	} tmr_state_t;

	typedef struct packed {
		logic [PRESC_W-1:0] count;
		logic tick;
	} div_state_t;

	typedef struct packed {
		logic meta;
		logic level;
		logic last;
	} sync_state_t;
endpackage : timer_pkg

`default_nettype wire

//--- hdl/prescale_divider.sv
/*
 * Power-of-two prescaler producing a one-cycle tick enable.
 * Assumes the select input comes from registers on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module prescale_divider
	import timer_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] prescale_select,
	output logic tick
);
	div_state_t s;
	div_state_t n;
	logic [PRESC_W-1:0] mask;

	// =====================================================================
	// free counter, tick when the selected low bits are all ones
	always_comb begin
		n = s;
		mask = PRESC_W'((8'h01 << prescale_select) - 8'h01);
		n.count = s.count + PRESC_W'(1);
		n.tick = ((s.count & mask) == mask);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick = s.tick;

	ratio_one_a: assert property (@(posedge clk) disable iff (reset)
		(prescale_select == 3'h0 && $past(prescale_select) == 3'h0) |=> tick)
		else $error("prescaler ratio one did not tick every cycle");
endmodule : prescale_divider

`default_nettype wire

//--- hdl/pin_edge_sync.sv
/*
 * Two-flop synchroniser with edge detection for the timer pin.
 * Assumes the pin is asynchronous to clk; edges are one-cycle pulses.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_edge_sync
	import timer_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	sync_state_t s;
	sync_state_t n;

	// =====================================================================
	// meta is read only by level; edges compare level with last
	always_comb begin
		n = s;
		n.meta = pin_in;
		n.level = s.meta;
		n.last = s.level;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign level = s.level;
	assign rise = s.level & ~s.last;
	assign fall = ~s.level & s.last;
endmodule : pin_edge_sync

`default_nettype wire

//--- hdl/reload_timer.sv
/*
 * Auto-reload capture/compare timer with AXI4-Lite register access.
 * One 16-bit unit or two 8-bit units, prescaler, edge counting, capture,
 * compare, PWM pin, gating and single-shot control.
 * Assumes a synchronous active-high reset and one 25 MHz clock; pin_in is
 * asynchronous, port_latch and port_drive come from logic on clk.
 */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module reload_timer
	import timer_pkg::*;
#(
	parameter bit HAS_PIN = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	input wire logic port_latch,
	input wire logic port_drive,
	output logic main_irq,
	output logic low_irq
);
	tmr_state_t s;
	tmr_state_t n;
	logic presc_tick;
	logic pin_lvl;
	logic pin_rise;
	logic pin_fall;
	logic cm;
	logic cap_mode;
	logic dual;
	logic sel_edge;
	logic ss_edge;
	logic gate_def;
	logic gated;
	logic run_eff;
	logic hi_tick;
	logic lo_tick;
	logic cap_ev;
	logic skip;
	logic ovf_h;
	logic ovf_l;
	logic match_h;
	logic match_l;
	logic wr;
	logic wlo;
	logic whi;
	logic ss_go;
	logic [15:0] d;
	logic [IDX_W-1:0] ridx;
	logic [15:0] rd;
	logic rd_hit;

	prescale_divider u_div (
		.clk(clk),
		.reset(reset),
		.prescale_select(s.cfg.prescale_select),
		.tick(presc_tick)
	);

	pin_edge_sync u_sync (
		.clk(clk),
		.reset(reset),
		.pin_in(pin_in),
		.level(pin_lvl),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// =====================================================================
	// mode decode
	always_comb begin
		dual = s.cfg.dual_byte_mode;
		cm = s.cfg.counter_timer_select && HAS_PIN;
		cap_mode = !cm && s.cfg.edge_function_select != EDGE_NONE && HAS_PIN;
		sel_edge = (s.cfg.edge_function_select[0] && pin_rise) ||
			(s.cfg.edge_function_select[1] && pin_fall);
		ss_edge = (s.cfg.edge_function_select == EDGE_BOTH) ?
			(s.ca.pin_polarity ? pin_fall : pin_rise) : sel_edge;
		// gating is dropped during a compare single-shot (SS_CMP) in dual mode
		gate_def = s.ca.gate_enable && !s.ca.pin_output_enable && !cm && HAS_PIN &&
			s.cfg.edge_function_select != EDGE_BOTH &&
			!(dual && s.ss == SS_CMP);
		gated = gate_def && (pin_lvl == s.ca.pin_polarity);
		run_eff = (s.ca.main_run && s.ss == SS_IDLE) ||
			s.ss == SS_CAPT || s.ss == SS_CMP;
		hi_tick = run_eff && (cm ? sel_edge : (presc_tick && !gated));
		lo_tick = dual && s.ca.low_unit_run && presc_tick;
		cap_ev = cap_mode && sel_edge && s.ss != SS_WAIT;
		skip = s.cfg.edge_function_select == EDGE_BOTH && s.ca.gate_enable &&
			(s.ca.pin_polarity ? pin_rise : pin_fall);
		wr = s.aw_full && s.w_full && !s.bvalid;
		wlo = wr && s.w_strb[0];
		whi = wr && s.w_strb[1];
		d = s.w_data;
		ridx = s_axi_araddr[ADDR_W-1:2];
	end

	// =====================================================================
	// register read mux
	always_comb begin
		rd = 16'h0000;
		rd_hit = 1'b1;
		case (ridx)
			IDX_CFG: rd = {ZERO_8, s.cfg};
			IDX_CTRL_A: rd = {ZERO_8, s.ca};
			IDX_CTRL_B: rd = {ZERO_8, s.cb};
			IDX_VALUE: rd = dual ? {ZERO_8, s.value[7:0]} : s.value;
			IDX_RELOAD: rd = dual ? {ZERO_8, s.reload[7:0]} : s.reload;
			IDX_CMP: rd = dual ? {ZERO_8, s.cmp[7:0]} : s.cmp;
			IDX_VALUE_HI: rd = {ZERO_8, s.value[15:8]};
			IDX_RELOAD_HI: rd = {ZERO_8, s.reload[15:8]};
			IDX_CMP_HI: rd = {ZERO_8, s.cmp[15:8]};
			default: rd_hit = 1'b0;
		endcase
	end

	// =====================================================================
	// next state
	always_comb begin
		n = s;
		ovf_h = 1'b0;
		ovf_l = 1'b0;
		match_h = 1'b0;
		match_l = 1'b0;
		ss_go = 1'b0;

		// counting, overflow reloads in the same cycle
		if (!dual) begin
			if (hi_tick) begin
				if (s.value == FULL_16) begin
					n.value = s.reload;
					ovf_h = 1'b1;
				end else begin
					n.value = s.value + 16'h0001;
				end
			end
			match_h = hi_tick && !cap_mode && n.value == s.cmp;
		end else begin
			if (hi_tick) begin
				if (s.value[15:8] == FULL_8) begin
					n.value[15:8] = s.reload[15:8];
					ovf_h = 1'b1;
				end else begin
					n.value[15:8] = s.value[15:8] + 8'h01;
				end
			end
			if (lo_tick) begin
				if (s.value[7:0] == FULL_8) begin
					n.value[7:0] = s.reload[7:0];
					ovf_l = 1'b1;
				end else begin
					n.value[7:0] = s.value[7:0] + 8'h01;
				end
			end
			match_h = hi_tick && !cap_mode && n.value[15:8] == s.cmp[15:8];
			match_l = lo_tick && n.value[7:0] == s.cmp[7:0];
		end

		// capture, with optional reload
		if (cap_ev) begin
			if (dual) begin
				n.cmp[15:8] = s.value[15:8];
			end else begin
				n.cmp = s.value;
			end
			if (s.ca.capture_reload_enable && !skip) begin
				if (dual) begin
					n.value[15:8] = s.reload[15:8];
				end else begin
					n.value = s.reload;
				end
			end
		end

		// single-shot sequencing
		case (s.ss)
			SS_IDLE: ;
			SS_WAIT: begin
				if (ss_edge || (gate_def && !gated)) begin
					n.ss = SS_CAPT;
				end
			end
			SS_CAPT: begin
				if (ss_edge) begin
					n.ss = SS_IDLE;
				end
			end
			SS_CMP: begin
				if (ovf_h) begin
					n.ss = SS_IDLE;
				end
			end
			default: n.ss = SS_IDLE;
		endcase
		if (s.ss != SS_IDLE && n.ss == SS_IDLE) begin
			n.ca.single_shot = 1'b0;
		end

		// write channel handshakes
		if (s_axi_awvalid && s.aw_rdy) begin
			n.aw_full = 1'b1;
			n.aw_idx = s_axi_awaddr[ADDR_W-1:2];
		end
		if (s_axi_wvalid && s.w_rdy) begin
			n.w_full = 1'b1;
			n.w_data = s_axi_wdata[15:0];
			n.w_strb = s_axi_wstrb[1:0];
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end

		// register writes; software value writes win over counting
		if (wr) begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			case (s.aw_idx)
				IDX_CFG: if (wlo) n.cfg = {1'b0, d[6:0]};
				IDX_CTRL_A: begin
					if (wlo) begin
						n.ca = ctrl_a_t'(d[7:0]);
						// counter mode single-shot is dropped
						ss_go = d[1] && s.ss == SS_IDLE && !cm &&
							(cap_mode || s.cfg.edge_function_select == EDGE_NONE);
						if (s.ss == SS_IDLE) begin
							n.ca.single_shot = ss_go;
						end else if (!d[1]) begin
							n.ss = SS_IDLE;
						end
					end
				end
				IDX_CTRL_B: begin
					if (wlo) begin
						n.cb.low_irq_enable = d[7];
						n.cb.main_overflow_flag = n.cb.main_overflow_flag & d[3];
						n.cb.low_overflow_flag = n.cb.low_overflow_flag & d[2];
						n.cb.capture_compare_flag = n.cb.capture_compare_flag & d[1];
						n.cb.low_compare_flag = n.cb.low_compare_flag & d[0];
					end
				end
				IDX_VALUE: begin
					if (wlo) n.value[7:0] = d[7:0];
					if (whi && !dual) n.value[15:8] = d[15:8];
				end
				IDX_RELOAD: begin
					if (wlo) n.reload[7:0] = d[7:0];
					if (whi && !dual) n.reload[15:8] = d[15:8];
				end
				IDX_CMP: begin
					if (wlo) n.cmp[7:0] = d[7:0];
					if (whi && !dual) n.cmp[15:8] = d[15:8];
				end
				IDX_VALUE_HI: if (wlo) n.value[15:8] = d[7:0];
				IDX_RELOAD_HI: if (wlo) n.reload[15:8] = d[7:0];
				IDX_CMP_HI: if (wlo) n.cmp[15:8] = d[7:0];
				default: n.bresp = RESP_SLVERR;
			endcase
		end
		if (ss_go) begin
			if (cap_mode) begin
				n.ss = SS_WAIT;
			end else begin
				n.ss = SS_CMP;
				if (dual) begin
					n.value[15:8] = s.reload[15:8];
				end else begin
					n.value = s.reload;
				end
			end
		end

		// flags: a set in the same cycle as a clear wins
		n.cb.main_overflow_flag = n.cb.main_overflow_flag | ovf_h;
		n.cb.capture_compare_flag = n.cb.capture_compare_flag | match_h | cap_ev;
		n.cb.low_overflow_flag = n.cb.low_overflow_flag | ovf_l;
		n.cb.low_compare_flag = n.cb.low_compare_flag | match_l;
		n.irq_main = n.ca.main_irq_enable &&
			(n.cb.main_overflow_flag || n.cb.capture_compare_flag);
		n.irq_low = n.cb.low_irq_enable &&
			(n.cb.low_overflow_flag || n.cb.low_compare_flag);

		// read channel
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.ar_rdy) begin
			n.rvalid = 1'b1;
			n.rdata = rd;
			n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		n.aw_rdy = !n.aw_full;
		n.w_rdy = !n.w_full;
		n.ar_rdy = !n.rvalid;

		// pwm waveform; polarity only latched on output enable rising
		if (!s.ca.pin_output_enable && n.ca.pin_output_enable) begin
			n.pwm_start = n.ca.pin_polarity;
			n.pwm = n.ca.pin_polarity;
		end else if (ovf_h) begin
			n.pwm = s.pwm_start;
		end else if (match_h) begin
			n.pwm = !s.pwm_start;
		end
		n.pin_out = (n.ca.pin_output_enable && HAS_PIN) ? n.pwm : port_latch;
		n.pin_oe = (n.ca.pin_output_enable && HAS_PIN) || port_drive;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = s.aw_rdy;
	assign s_axi_wready = s.w_rdy;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.ar_rdy;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = {16'h0000, s.rdata};
	assign s_axi_rresp = s.rresp;
	assign pin_out = s.pin_out;
	assign pin_oe = s.pin_oe;
	assign main_irq = s.irq_main;
	assign low_irq = s.irq_low;

	// =====================================================================
	// checks
	default clocking cb_clk @(posedge clk); endclocking
	default disable iff (reset);

	sequence ss_armed;
		s.ss == SS_WAIT && !s.cb.capture_compare_flag && !wr;
	endsequence

	irq_gating_a: assert property (main_irq == (s.ca.main_irq_enable &&
		(s.cb.main_overflow_flag || s.cb.capture_compare_flag)))
		else $error("main interrupt does not follow enable and flags");
	ovf_reload_a: assert property ((!dual && hi_tick && s.value == FULL_16 &&
		!cap_ev && !wr) |=> (s.value == $past(s.reload) && s.cb.main_overflow_flag))
		else $error("overflow did not reload or flag");
	freeze_a: assert property ((s.ss == SS_IDLE && !s.ca.main_run && !dual &&
		!cap_ev && !wr) |=> $stable(s.value))
		else $error("stopped timer changed its count");
	start_level_a: assert property ((HAS_PIN && $rose(s.ca.pin_output_enable)) |->
		(pin_out == s.ca.pin_polarity))
		else $error("pin did not start at polarity level");
	capture_a: assert property ((cap_ev && !dual && !wr) |=>
		(s.cb.capture_compare_flag && s.cmp == $past(s.value)))
		else $error("capture edge lost value or flag");
	ss_start_a: assert property (ss_armed ##0 ss_edge |=>
		(s.ss == SS_CAPT && !s.cb.capture_compare_flag))
		else $error("single-shot start edge misbehaved");
	dual_zero_a: assert property ((s_axi_arvalid && s.ar_rdy && dual &&
		ridx == IDX_VALUE) |=> (s.rdata[15:8] == ZERO_8))
		else $error("upper value byte not zero in dual mode");
	low_quiet_a: assert property ((!dual && !s.cb.low_overflow_flag && !wr) |=>
		!s.cb.low_overflow_flag)
		else $error("low overflow flag set in 16-bit mode");
	count_edge_a: assert property ((cm && s.ss == SS_IDLE && s.ca.main_run &&
		!dual && sel_edge && s.value != FULL_16 && !wr) |=>
		(s.value == $past(s.value) + 16'h0001))
		else $error("counter mode missed a pin edge");
	gate_hold_a: assert property ((gated && !dual && !cap_ev && !wr) |=>
		$stable(s.value))
		else $error("gated timer advanced");
endmodule : reload_timer

`default_nettype wire

//--- dv/pin_model.sv
/*
 * Far-side model of the timer pin: an outside driver that makes pulses.
 * Assumes the bench calls pulse() just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_model (
	input wire logic clk,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_in
);
	logic ext_q = 1'h0;

	// =====================================================================
	// wire level: the timer wins while it enables its driver
	assign pin_in = pin_oe ? pin_out : ext_q;

	// =====================================================================
	// pulses last 4 cycles per level so the two-flop sync never misses one
	task automatic pulse(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			ext_q <= 1'h1;
			repeat (4) @(posedge clk);
			ext_q <= 1'h0;
		end
	endtask : pulse
endmodule : pin_model

`default_nettype wire

//--- dv/tb_top.sv
/*
 * Self-checking bench for reload_timer: AXI4-Lite master, pin model, scoreboard.
 * Assumes timer_pkg and the pin model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin mismatches++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (x)); end end

module tb_top
	import timer_pkg::*;
;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic port_latch = 1'h0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic awready, wready, bvalid, arready, rvalid, pin_in, pin_out, pin_oe;
	logic main_irq, low_irq;
	logic [1:0] bresp, rresp, eb;
	logic [33:0] e;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [31:0] seed = 32'h00014356;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;

	reload_timer uut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.port_latch(port_latch), .port_drive(1'h0), .main_irq(main_irq),
		.low_irq(low_irq));

	pin_model pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

	initial forever #20 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	// =====================================================================
	// bus master: valid held until its ready, the answer waited for
	task automatic wr(input logic [4:0] i, input logic [15:0] d,
		input logic [1:0] r = RESP_OKAY);
		@(posedge clk);
		bq.push_back(r);
		awaddr <= {i, 2'h0};
		wdata <= {16'h0000, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!(bvalid && bready));
		bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [4:0] i, input logic [15:0] d,
		input logic [1:0] r = RESP_OKAY);
		@(posedge clk);
		rq.push_back({r, 16'h0000, d});
		araddr <= {i, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (!(rvalid && rready));
		rready <= 1'h0;
	endtask : rd

	// =====================================================================
	// scoreboard: oldest note against each answer; also the hang limit
	always @(posedge clk) begin
		if (rvalid && rready) begin
			e = rq.pop_front();
			`CHK({rresp, rdata}, e)
		end
		if (bvalid && bready) begin
			eb = bq.pop_front();
			`CHK(bresp, eb)
		end
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end

	// =====================================================================
	// scenarios
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'h0;
		rd(IDX_CFG, 16'h0000);
		rd(IDX_CTRL_A, 16'h0000);
		rd(IDX_CTRL_B, 16'h0000);
		rd(5'h1F, 16'h0000, RESP_SLVERR);
		wr(5'h1F, 16'hFFFF, RESP_SLVERR);
		wr(IDX_CFG, 16'hFFFF);
		rd(IDX_CFG, 16'h007F);
		wr(IDX_CFG, 16'h0000);
		wr(IDX_CTRL_B, 16'h00FF);
		rd(IDX_CTRL_B, 16'h0080);
		wr(IDX_CTRL_B, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			wr(IDX_RELOAD, seed[15:0]);
			rd(IDX_RELOAD, seed[15:0]);
		end
		// dual mode hides the upper bytes behind the high registers
		wr(IDX_CFG, 16'h0008);
		wr(IDX_RELOAD, 16'hABCD);
		rd(IDX_RELOAD, 16'h00CD);
		wr(IDX_RELOAD_HI, 16'h0012);
		rd(IDX_RELOAD_HI, 16'h0012);
		wr(IDX_CFG, 16'h0000);
		// overflow with reload, flag and interrupt gating
		wr(IDX_CMP, 16'h1234);
		wr(IDX_RELOAD, 16'hFFF0);
		wr(IDX_VALUE, 16'hFFFE);
		wr(IDX_CTRL_A, 16'h0088);
		repeat (30) @(posedge clk);
		rd(IDX_CTRL_B, 16'h0008);
		`CHK(main_irq, 1'h1)
		wr(IDX_CTRL_A, 16'h0008);
		repeat (3) @(posedge clk);
		`CHK(main_irq, 1'h0)
		wr(IDX_CTRL_A, 16'h0000);
		wr(IDX_CTRL_B, 16'h0000);
		rd(IDX_CTRL_B, 16'h0000);
		// edge counting; single_shot is never set while counting
		wr(IDX_VALUE, 16'h0000);
		wr(IDX_CFG, 16'h0003);
		wr(IDX_CTRL_A, 16'h0008);
		pins.pulse(3);
		repeat (6) @(posedge clk);
		wr(IDX_CTRL_A, 16'h0000);
		rd(IDX_VALUE, 16'h0003);
		// rising-edge capture in timer mode
		wr(IDX_CFG, 16'h0002);
		wr(IDX_CTRL_A, 16'h0008);
		pins.pulse(1);
		repeat (6) @(posedge clk);
		rd(IDX_CTRL_B, 16'h0002);
		wr(IDX_CTRL_A, 16'h0000);
		wr(IDX_CTRL_B, 16'h0000);
		wr(IDX_CFG, 16'h0000);
		// low unit in dual mode: overflow, compare and its own interrupt
		wr(IDX_CFG, 16'h0008);
		wr(IDX_VALUE, 16'h00F0);
		wr(IDX_RELOAD, 16'h00F0);
		wr(IDX_CMP, 16'h00F8);
		wr(IDX_CTRL_B, 16'h0080);
		wr(IDX_CTRL_A, 16'h0010);
		repeat (40) @(posedge clk);
		rd(IDX_CTRL_B, 16'h0085);
		`CHK(low_irq, 1'h1)
		wr(IDX_CTRL_A, 16'h0000);
		wr(IDX_CTRL_B, 16'h0000);
		`CHK(low_irq, 1'h0)
		wr(IDX_CFG, 16'h0000);
		// compare match and overflow in 16-bit mode, reload is FFF0
		wr(IDX_VALUE, 16'hFFF0);
		wr(IDX_CMP, 16'hFFF8);
		wr(IDX_CTRL_A, 16'h0008);
		repeat (40) @(posedge clk);
		rd(IDX_CTRL_B, 16'h000A);
		wr(IDX_CTRL_A, 16'h0000);
		wr(IDX_CTRL_B, 16'h0000);
		// pin ownership and starting level; latch low so polarity shows
		wr(IDX_CTRL_A, 16'h0060);
		repeat (2) @(posedge clk);
		`CHK(pin_out, 1'h1)
		`CHK(pin_oe, 1'h1)
		wr(IDX_CTRL_A, 16'h0040);
		`CHK(pin_out, 1'h1)
		wr(IDX_CTRL_A, 16'h0000);
		repeat (2) @(posedge clk);
		`CHK(pin_out, 1'h0)
		`CHK(pin_oe, 1'h0)
		port_latch <= 1'h1;
		repeat (2) @(posedge clk);
		`CHK(pin_out, 1'h1)
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule : tb_top

`default_nettype wire
